// ==== sim/switch_reset_strap_config_tb.sv ====
// Self-checking bench of the reset, strap and pin block
`timescale 1ns/1ps
module switch_reset_strap_config_tb
  import sysctl_pkg::*;
;
  // Bus and reset
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  // Straps and board drive
  logic hold_in_reset = 0, common_clock_downstream = 0, common_clock_upstream = 0, eeprom_bus_slow_mode = 0;
  logic aux_power_disable_n = 1, general_event = 0, ext_wake_n = 1;
  logic [2:0] switch_op_mode = '0, expander_irq_n;
  logic [10:0] ext_oe = '0, ext_val = '0, gpio_in, gpio_out, gpio_oe_n;
  // Core side
  logic wake_in_n, wake_out_n, wake_oe_n, core_reset_n, aux_power_en, eeprom_init_req, eeprom_bit_tick;
  logic us_slot_clock;
  logic [1:0] op_mode;
  logic [3:0] ds_slot_clock;
  int n_mismatch = 0, checks_done = 0;
  switch_reset_strap_config switch_reset_strap_config_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hold_in_reset(hold_in_reset),
    .switch_op_mode(switch_op_mode), .common_clock_downstream(common_clock_downstream),
    .common_clock_upstream(common_clock_upstream), .eeprom_bus_slow_mode(eeprom_bus_slow_mode),
    .aux_power_disable_n(aux_power_disable_n), .wake_in_n(wake_in_n), .wake_out_n(wake_out_n),
    .wake_oe_n(wake_oe_n), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
    .general_event(general_event), .core_reset_n(core_reset_n), .aux_power_en(aux_power_en),
    .op_mode(op_mode), .eeprom_init_req(eeprom_init_req), .eeprom_bit_tick(eeprom_bit_tick),
    .expander_irq_n(expander_irq_n), .ds_slot_clock(ds_slot_clock), .us_slot_clock(us_slot_clock)
  );
  sysctl_board sysctl_board_i (
    .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .wake_out_n(wake_out_n), .wake_oe_n(wake_oe_n),
    .ext_oe(ext_oe), .ext_val(ext_val), .ext_wake_n(ext_wake_n), .gpio_in(gpio_in), .wake_in_n(wake_in_n)
  );
  // Clock
  initial forever #5 pclk = ~pclk;
  // Watchdog
  initial begin
    #300us;
    n_mismatch++;
    print_verdict();
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // One bus transfer, then an idle cycle
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // Reset with given straps, then move the mode and clock straps
  task automatic rst(input logic h, input logic [2:0] m, input logic s);
    hold_in_reset <= h;
    switch_op_mode <= m;
    common_clock_downstream <= m[0];
    common_clock_upstream <= !m[0];
    eeprom_bus_slow_mode <= s;
    presetn <= 0;
    cyc(4);
    presetn <= 1;
    cyc(3);
    switch_op_mode <= ~m;
    common_clock_downstream <= !m[0];
    common_clock_upstream <= m[0];
  endtask
  // Mode codes 0, 1, 2 and 7 and the strap seeds
  task automatic t_modes;
    logic [2:0] ms [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
    foreach (ms[k]) begin
      rst(0, ms[k], 0);
      for (int i = 0; i < 40 && core_reset_n !== 1'b1; i++) @(posedge pclk);
      chk(core_reset_n, 1);
      chk(op_mode, ms[k] == 0 ? OPM_NORMAL : ms[k] == 1 ? OPM_EEPROM : OPM_RESERVED);
      chk(eeprom_init_req, ms[k] == 1);
      chk(ds_slot_clock, {4{ms[k][0]}});
      chk(us_slot_clock, !ms[k][0]);
      bus(0, 12'h020, '0);
      chk(rd, {!ms[k][0], ms[k][0], ms[k]});
    end
  endtask
  // Software overrides the slot clock bits
  task automatic t_slot;
    bus(1, 12'h004, '0);
    bus(1, 12'h008, 32'h0000_1000);
    chk(ds_slot_clock, 4'h0);
    chk(us_slot_clock, 1);
  endtask
  // Held reset, alternate pins, release by software
  task automatic t_hold;
    rst(1, 3'h0, 0);
    cyc(40);
    chk(core_reset_n, 0);
    bus(1, 12'h010, 32'h0000_069F);
    ext_oe <= 11'h01C;
    ext_val <= 11'h014;
    general_event <= 1;
    cyc(4);
    chk(expander_irq_n, 3'h5);
    chk(gpio_out & 11'h683, 11'h000);
    chk(gpio_oe_n & 11'h683, 11'h000);
    bus(0, 12'h024, '0);
    chk(rd[0], 1);
    bus(0, 12'h000, '0);
    chk(rd[0], 1);
    bus(1, 12'h000, '0);
    cyc(4);
    chk(core_reset_n, 1);
    general_event <= 0;
    cyc(4);
    chk(gpio_out & 11'h683, 11'h683);
  endtask
  // Plain pins, wake pin, aux power, unmapped place
  task automatic t_pins;
    bus(1, 12'h010, '0);
    bus(1, 12'h018, 32'h0000_00F0);
    bus(1, 12'h014, 32'h0000_00A0);
    ext_oe <= 11'h70F;
    ext_val <= 11'h505;
    cyc(4);
    chk(gpio_oe_n, 11'h70F);
    bus(0, 12'h01C, '0);
    chk(rd, 32'h0000_05A5);
    bus(1, 12'h00C, 32'h0000_0003);
    chk(wake_oe_n, 0);
    chk(wake_out_n, 0);
    bus(1, 12'h00C, 32'h0000_0002);
    chk(wake_oe_n, 1);
    bus(1, 12'h00C, '0);
    ext_wake_n <= 0;
    aux_power_disable_n <= 0;
    cyc(4);
    chk(wake_oe_n, 1);
    chk(aux_power_en, 0);
    bus(0, 12'h00C, '0);
    chk(rd[2], 1);
    aux_power_disable_n <= 1;
    bus(0, 12'h040, '0);
    chk(err, 1);
    chk(rd, 0);
  endtask
  // Bus tick spacing for both strap levels
  task automatic t_speed;
    int n;
    for (int s = 0; s < 2; s++) begin
      rst(0, 3'h0, s[0]);
      bus(1, 12'h020, 32'hFFFF_FFFF);
      n = 0;
      while (eeprom_bit_tick !== 1'b1 && n < 600) begin
        @(posedge pclk);
        n++;
      end
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (eeprom_bit_tick !== 1'b1 && n < 600);
      chk(n, s ? 250 : 62);
    end
  endtask
  // Verdict and end of run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    t_modes();
    t_slot();
    t_hold();
    t_pins();
    t_speed();
    print_verdict();
  end
endmodule

// ==== sim/sysctl_board.sv ====
// Board model: pin pull-ups, board drivers and the open-drain wake wire
`timescale 1ns/1ps
module sysctl_board (
  // Device pin drive
  input wire logic [10:0] gpio_out,
  input wire logic [10:0] gpio_oe_n,
  input wire logic wake_out_n,
  input wire logic wake_oe_n,
  // Board drive, enable high
  input wire logic [10:0] ext_oe,
  input wire logic [10:0] ext_val,
  input wire logic ext_wake_n,
  // Levels seen at the pins
  output logic [10:0] gpio_in,
  output logic wake_in_n
);
  // Device drive wins, then board, then the pull-up
  assign gpio_in = (~gpio_oe_n & gpio_out) | (gpio_oe_n & ((ext_oe & ext_val) | ~ext_oe));
  // Wire-and of both open-drain drivers
  assign wake_in_n = (wake_oe_n | wake_out_n) & ext_wake_n;
endmodule

// ==== sim/sysctl_monitor.sv ====
// Port checker for the reset, strap and pin block
`timescale 1ns/1ps
module sysctl_monitor
  import sysctl_pkg::*;
(
  // Clock, reset, bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  // Straps and aux power disable input
  input wire logic [2:0] switch_op_mode,
  input wire logic common_clock_downstream,
  input wire logic common_clock_upstream,
  input wire logic eeprom_bus_slow_mode,
  input wire logic aux_power_disable_n,
  // Outputs
  input wire logic [10:0] gpio_oe_n,
  input wire logic core_reset_n,
  input wire logic aux_power_en,
  input wire logic [1:0] op_mode,
  input wire logic eeprom_init_req,
  input wire logic eeprom_bit_tick,
  input wire logic [3:0] ds_slot_clock,
  input wire logic us_slot_clock
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [8:0] gap_q; // Cycles since last tick
  logic seen_q; // First tick passed
  logic [2:0] age_q; // Cycles since release, saturating
  // Tick spacing and release age counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 9'h000;
      seen_q <= 1'b0;
      age_q <= 3'h0;
    end else begin
      gap_q <= eeprom_bit_tick ? 9'h001 : gap_q + 9'h001;
      seen_q <= seen_q | eeprom_bit_tick;
      age_q <= (age_q == 3'h7) ? age_q : age_q + 3'h1;
    end
  end
  property p_first; $rose(presetn) |-> !core_reset_n && gpio_oe_n == 11'h7FF; endproperty
  a_first: assert property (p_first) else $error("not in reset state");
  property p_proc; $rose(presetn) |-> !core_reset_n [*8] ##1 !core_reset_n [*8]; endproperty
  a_proc: assert property (p_proc) else $error("reset procedure cut short");
  property p_slot;
    $rose(presetn) |-> ##3 ds_slot_clock == {4{$past(common_clock_downstream, 3)}} &&
      us_slot_clock == $past(common_clock_upstream, 3);
  endproperty
  a_slot: assert property (p_slot) else $error("slot clock seed wrong");
  property p_mode;
    $rose(presetn) |-> ##3 op_mode == ($past(switch_op_mode, 3) == 3'h0 ? OPM_NORMAL :
      $past(switch_op_mode, 3) == 3'h1 ? OPM_EEPROM : OPM_RESERVED);
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  property p_keep;
    !(psel && penable && pwrite) && age_q >= 3'h3 |=>
      $stable(ds_slot_clock) && $stable(us_slot_clock) && $stable(op_mode);
  endproperty
  a_keep: assert property (p_keep) else $error("strap value moved");
  property p_aux; (!aux_power_disable_n) [*4] |-> !aux_power_en; endproperty
  a_aux: assert property (p_aux) else $error("aux power used");
  property p_tick; eeprom_bit_tick && seen_q |-> gap_q == (eeprom_bus_slow_mode ? 9'h0FA : 9'h03E); endproperty
  a_tick: assert property (p_tick) else $error("bus rate wrong");
  property p_req; eeprom_init_req == (op_mode == OPM_EEPROM); endproperty
  a_req: assert property (p_req) else $error("init request wrong");
  // Main scenarios
  c_run: cover property ($rose(core_reset_n));
  c_slow: cover property (eeprom_bit_tick && seen_q && eeprom_bus_slow_mode);
  c_aux: cover property (!aux_power_en ##1 aux_power_en);
endmodule
bind switch_reset_strap_config sysctl_monitor sysctl_monitor_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .switch_op_mode(switch_op_mode), .common_clock_downstream(common_clock_downstream),
  .common_clock_upstream(common_clock_upstream), .eeprom_bus_slow_mode(eeprom_bus_slow_mode),
  .aux_power_disable_n(aux_power_disable_n), .gpio_oe_n(gpio_oe_n), .core_reset_n(core_reset_n),
  .aux_power_en(aux_power_en), .op_mode(op_mode), .eeprom_init_req(eeprom_init_req),
  .eeprom_bit_tick(eeprom_bit_tick), .ds_slot_clock(ds_slot_clock), .us_slot_clock(us_slot_clock)
);

// ==== src/rate_divider.sv ====
// Programmable divider producing a one-cycle quarter-bit tick
`timescale 1ns/1ps
`include "sysctl_regs.svh"
module rate_divider (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  input wire logic [9:0] limit,
  // Tick out
  output logic tick
);
  // Count register
  logic [9:0] cnt_q;

  // Counts to limit minus one and wraps, emitting a tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 10'h000;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_q <= 10'h000;
      tick <= 1'b0;
    end else if (cnt_q >= limit - 10'h001) begin
      cnt_q <= 10'h000;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 10'h001;
      tick <= 1'b0;
    end
  end
endmodule

// ==== src/switch_reset_strap_config.sv ====
// Reset sequencing, strap decode and system pin control of the switch
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "sysctl_regs.svh"
// Summary of operation
// - Pin 7 alternate drives general event output
// - Pin 9 alternate drives port 3 reset
// - Pin 10 alternate drives port 5 reset
// - Non-alternate pins work as plain GPIO
// - Downstream strap seeds downstream slot clock bits
// - Software write replaces downstream slot clock bit
// - Upstream strap seeds upstream slot clock bit
// - Software write replaces upstream slot clock bit
// - Slow strap gives 100 kHz, else 400
// - Bus speed has no register override
// - Fundamental reset clears all and starts reset
// - Hold input keeps device in reset, buses alive
// - Clearing hold bit releases device to run
// - Mode strap: 0 normal, 1 EEPROM, rest reserved
// - Wake pin direction follows control register bit
// - Aux power unused while disable input active
// - Pins 0 and 1 drive ports 2,4 resets
// - Pins 2 to 4 are expander interrupt inputs
module switch_reset_strap_config
  import sysctl_pkg::*;
(
  // Clock and fundamental reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Strap and system inputs
  input wire logic hold_in_reset,
  input wire logic [2:0] switch_op_mode,
  input wire logic common_clock_downstream,
  input wire logic common_clock_upstream,
  input wire logic eeprom_bus_slow_mode,
  input wire logic aux_power_disable_n,
  // Wake pin, open drain
  input wire logic wake_in_n,
  output logic wake_out_n,
  output logic wake_oe_n,
  // General purpose pins
  input wire logic [10:0] gpio_in,
  output logic [10:0] gpio_out,
  output logic [10:0] gpio_oe_n,
  // Core side
  input wire logic general_event,
  output logic core_reset_n,
  output logic aux_power_en,
  output logic [1:0] op_mode,
  output logic eeprom_init_req,
  output logic eeprom_bit_tick,
  output logic [2:0] expander_irq_n,
  output logic [3:0] ds_slot_clock,
  output logic us_slot_clock
);

  // Whole module state
  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [10:0] gin1;
    logic [10:0] gin2;
    logic [5:0] strap1; // Strap pins, first sync stage
    logic [5:0] strap2; // Strap pins, second sync stage
    logic ev; // Core event, registered once
    logic [2:0] mode;
    logic cds;
    logic cus;
    logic slow;
    logic strap_done;
    seq_state_e st;
    logic [4:0] cnt;
    logic hold;
    logic [3:0] ds_sclk;
    logic us_sclk;
    logic wake_dir;
    logic wake_drv;
    logic [10:0] alt;
    logic [10:0] gout;
    logic [10:0] goe;
    logic [31:0] rdata;
  } state_s;

  // Current and next state
  state_s s_q;
  state_s s_d;
  // Synchronised levels
  logic hold_s;
  logic apd_s;
  logic wake_s;
  // Divider tick
  logic tick;
  // Bus decode
  logic wr_en;
  logic rd_en;
  logic hit;
  // Reset to ports, shared among port outputs
  logic port_rst_n;
  // Alternate pin functions
  logic gp_event_out_n;
  logic port2_reset_out_n;
  logic port3_reset_out_n;
  logic port4_reset_out_n;
  logic port5_reset_out_n;

  // Synchronised pins, second stage only
  assign hold_s = s_q.sync2[0];
  assign apd_s = s_q.sync2[1];
  assign wake_s = s_q.sync2[2];

  // APB writes in access phase, reads in setup phase, zero wait
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign prdata = s_q.rdata;

  // Address decode
  always_comb begin
    case (paddr)
      `SWCTL_OFS, `DS_LSTS_OFS, `US_LSTS_OFS, `WAKE_CTL_OFS, `GPIO_ALT_OFS,
      `GPIO_OUT_OFS, `GPIO_OE_OFS, `GPIO_IN_OFS, `STRAP_OFS, `EVENT_OFS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Error on unmapped access
  assign pslverr = psel && penable && !hit;

  // Bus clock speed from the strap only, no register path
  rate_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(s_q.strap_done),
    .limit(s_q.slow ? 10'(`EE_SLOW_DIV) : 10'(`EE_FAST_DIV)),
    .tick(tick)
  );
  assign eeprom_bit_tick = tick;

  // Next state logic
  always_comb begin
    s_d = s_q;
    // Two-stage synchronisers
    s_d.sync1 = {wake_in_n, ~aux_power_disable_n, hold_in_reset};
    s_d.sync2 = s_q.sync1;
    s_d.gin1 = gpio_in;
    s_d.gin2 = s_q.gin1;
    // Core event is on this clock, one register only
    s_d.ev = general_event;
    // Strap pins pass two flops like every other pin
    s_d.strap1 = {eeprom_bus_slow_mode, common_clock_upstream, common_clock_downstream, switch_op_mode};
    s_d.strap2 = s_q.strap1;
    // Capture once the sync chain holds the reset-time level, then freeze
    // Board must keep straps steady for a few cycles after release
    if (!s_q.strap_done && s_q.cnt == 5'(`STRAP_CAP_CYC)) begin
      s_d.mode = s_q.strap2[2:0];
      s_d.cds = s_q.strap2[3];
      s_d.cus = s_q.strap2[4];
      s_d.slow = s_q.strap2[5];
      s_d.ds_sclk = {4{s_q.strap2[3]}};
      s_d.us_sclk = s_q.strap2[4];
      s_d.strap_done = 1'b1;
    end
    // Reset procedure sequencer
    case (s_q.st)
      ST_PROC: begin
        // Synchronised hold input decides at the end of the procedure
        if (s_q.cnt == 5'(`RST_PROC_CYC - 1)) begin
          s_d.cnt = 5'h00;
          if (hold_s) begin
            s_d.st = ST_HOLD;
            s_d.hold = 1'b1;
          end else begin
            s_d.st = ST_RUN;
          end
        end else begin
          s_d.cnt = s_q.cnt + 5'h01;
        end
      end
      ST_HOLD: begin
        // Leave when software clears the hold bit
        if (!s_q.hold) begin
          s_d.st = ST_RUN;
        end
      end
      ST_RUN: begin
        // Stays here until the next fundamental reset
        s_d.st = ST_RUN;
      end
      default: begin
        s_d.st = ST_PROC;
      end
    endcase
    // Register writes
    if (wr_en) begin
      case (paddr)
        `SWCTL_OFS: begin
          // Only clearing of the hold bit has effect, and only once held,
          // so entering the held state wins over a clear in the same cycle
          if (!pwdata[`SWCTL_HOLD_BIT] && (s_q.st == ST_HOLD)) begin
            s_d.hold = 1'b0;
          end
        end
        `DS_LSTS_OFS: begin
          s_d.ds_sclk = {4{pwdata[`LSTS_SCLK_BIT]}};
        end
        `US_LSTS_OFS: begin
          s_d.us_sclk = pwdata[`LSTS_SCLK_BIT];
        end
        `WAKE_CTL_OFS: begin
          s_d.wake_dir = pwdata[`WAKE_DIR_BIT];
          s_d.wake_drv = pwdata[`WAKE_OUT_BIT];
        end
        `GPIO_ALT_OFS: begin
          s_d.alt = pwdata[10:0];
        end
        `GPIO_OUT_OFS: begin
          s_d.gout = pwdata[10:0];
        end
        `GPIO_OE_OFS: begin
          s_d.goe = pwdata[10:0];
        end
        default: begin
          s_d.alt = s_d.alt;
        end
      endcase
    end
    // Read data captured in setup phase
    if (rd_en) begin
      s_d.rdata = 32'h0000_0000;
      case (paddr)
        `SWCTL_OFS: begin
          s_d.rdata[`SWCTL_HOLD_BIT] = s_q.hold;
          s_d.rdata[`SWCTL_RUN_BIT] = (s_q.st == ST_RUN);
          s_d.rdata[`SWCTL_AUX_BIT] = !apd_s;
        end
        `DS_LSTS_OFS: s_d.rdata[`LSTS_SCLK_BIT] = s_q.ds_sclk[0];
        `US_LSTS_OFS: s_d.rdata[`LSTS_SCLK_BIT] = s_q.us_sclk;
        `WAKE_CTL_OFS: begin
          s_d.rdata[`WAKE_DIR_BIT] = s_q.wake_dir;
          s_d.rdata[`WAKE_OUT_BIT] = s_q.wake_drv;
          s_d.rdata[`WAKE_IN_BIT] = !wake_s;
        end
        `GPIO_ALT_OFS: s_d.rdata[10:0] = s_q.alt;
        `GPIO_OUT_OFS: s_d.rdata[10:0] = s_q.gout;
        `GPIO_OE_OFS: s_d.rdata[10:0] = s_q.goe;
        `GPIO_IN_OFS: s_d.rdata[10:0] = s_q.gin2;
        `STRAP_OFS: s_d.rdata[5:0] = {s_q.slow, s_q.cus, s_q.cds, s_q.mode};
        `EVENT_OFS: s_d.rdata[0] = s_q.ev;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register; fundamental reset clears everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Core held in reset until sequencer runs
  assign core_reset_n = (s_q.st == ST_RUN);
  assign port_rst_n = presetn && (s_q.st == ST_RUN);

  // Downstream port resets and the event output, active low
  assign port2_reset_out_n = port_rst_n;
  assign port3_reset_out_n = port_rst_n;
  assign port4_reset_out_n = port_rst_n;
  assign port5_reset_out_n = port_rst_n;
  assign gp_event_out_n = !s_q.ev;

  // Mode decode
  always_comb begin
    case (s_q.mode)
      `MODE_NORMAL: op_mode = OPM_NORMAL;
      `MODE_EEPROM: op_mode = OPM_EEPROM;
      default: op_mode = OPM_RESERVED;
    endcase
  end
  assign eeprom_init_req = (s_q.mode == `MODE_EEPROM) && s_q.strap_done;

  // Aux power use gated by the disable input
  assign aux_power_en = s_q.strap_done && !apd_s;

  // Wake pin: drive only when direction is output
  // Open drain: only ever pulled low, the board pull-up gives high
  assign wake_out_n = 1'b0;
  assign wake_oe_n = !(s_q.wake_dir && s_q.wake_drv);

  // Slot clock configuration outputs
  assign ds_slot_clock = s_q.ds_sclk;
  assign us_slot_clock = s_q.us_sclk;

  // Expander interrupt inputs on pins 2 to 4, high when unselected
  assign expander_irq_n = s_q.gin2[4:2] | ~s_q.alt[4:2];

  // Pin output mux: alternate functions override GPIO
  always_comb begin
    gpio_out = s_q.gout;
    gpio_oe_n = ~s_q.goe;
    if (s_q.alt[0]) begin
      gpio_out[0] = port2_reset_out_n;
      gpio_oe_n[0] = 1'b0;
    end
    if (s_q.alt[1]) begin
      gpio_out[1] = port4_reset_out_n;
      gpio_oe_n[1] = 1'b0;
    end
    // Interrupt inputs: pin released so the expander can pull it
    if (s_q.alt[2]) begin
      gpio_oe_n[2] = 1'b1;
    end
    if (s_q.alt[3]) begin
      gpio_oe_n[3] = 1'b1;
    end
    if (s_q.alt[4]) begin
      gpio_oe_n[4] = 1'b1;
    end
    if (s_q.alt[7]) begin
      gpio_out[7] = gp_event_out_n;
      gpio_oe_n[7] = 1'b0;
    end
    if (s_q.alt[9]) begin
      gpio_out[9] = port3_reset_out_n;
      gpio_oe_n[9] = 1'b0;
    end
    if (s_q.alt[10]) begin
      gpio_out[10] = port5_reset_out_n;
      gpio_oe_n[10] = 1'b0;
    end
  end
endmodule

// ==== src/sysctl_pkg.sv ====
// Types shared by the system control block
package sysctl_pkg;

  // Reset sequencer states, Gray coded along the usual path
  typedef enum logic [1:0] {
    ST_PROC = 2'b00,
    ST_RUN = 2'b01,
    ST_HOLD = 2'b11,
    ST_SPARE = 2'b10
  } seq_state_e;

  // Decoded switch operating mode
  typedef enum logic [1:0] {
    OPM_NORMAL = 2'b00,
    OPM_EEPROM = 2'b01,
    OPM_RESERVED = 2'b10
  } op_mode_e;

endpackage

// ==== src/sysctl_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the system control block
`ifndef SYSCTL_REGS_SVH
`define SYSCTL_REGS_SVH

// Register byte offsets
`define SWCTL_OFS 12'h000
`define DS_LSTS_OFS 12'h004
`define US_LSTS_OFS 12'h008
`define WAKE_CTL_OFS 12'h00C
`define GPIO_ALT_OFS 12'h010
`define GPIO_OUT_OFS 12'h014
`define GPIO_OE_OFS 12'h018
`define GPIO_IN_OFS 12'h01C
`define STRAP_OFS 12'h020
`define EVENT_OFS 12'h024

// Field positions
`define SWCTL_HOLD_BIT 0
`define SWCTL_RUN_BIT 1
`define SWCTL_AUX_BIT 2
`define LSTS_SCLK_BIT 12
`define WAKE_DIR_BIT 0
`define WAKE_OUT_BIT 1
`define WAKE_IN_BIT 2

// Reset values
`define GPIO_ALT_RST 11'h000
`define GPIO_OUT_RST 11'h000
`define GPIO_OE_RST 11'h000

// Switch mode codes
`define MODE_NORMAL 3'h0
`define MODE_EEPROM 3'h1

// Timing: EEPROM bus clock rates and system clock, kHz
`define SYS_CLK_KHZ 100000
`define EE_SLOW_KHZ 100
`define EE_FAST_KHZ 400
`define EE_SLOW_DIV (`SYS_CLK_KHZ / (`EE_SLOW_KHZ * 4))
`define EE_FAST_DIV (`SYS_CLK_KHZ / (`EE_FAST_KHZ * 4))

// Reset procedure length in cycles
`define RST_PROC_CYC 16

// Procedure cycle at which the synchronised straps are captured
`define STRAP_CAP_CYC 2

`endif
